// ### rtl/hwmon_pkg.sv
package hwmon_pkg;

	// ----------------------------------------
	// channels and widths
	// ----------------------------------------
	localparam int NUM_CH    = 8;
	localparam int CH_W      = 3;
	localparam int DATA_W    = 8;
	// channel order: 12v, 5v, 3.3v, 2.5v, core, own supply, int temp, ext temp
	localparam logic [CH_W-1:0] CH_12V  = 3'h0;
	localparam logic [CH_W-1:0] CH_LAST = 3'h7;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_ID_LO  = 8'h04;
	localparam logic [7:0] OFF_ID_HI  = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_MASK   = 8'h10;
	localparam logic [7:0] OFF_ADDR   = 8'h14;
	localparam logic [7:0] OFF_TEST   = 8'h18;
	localparam logic [7:0] OFF_VALUE  = 8'h20;
	localparam logic [7:0] OFF_HIGH   = 8'h40;
	localparam logic [7:0] OFF_LOW    = 8'h60;

	// ----------------------------------------
	// config fields
	// ----------------------------------------
	localparam int CFG_RUN      = 0;
	localparam int CFG_DIGITAL4 = 1;
	localparam int CFG_FN_LO    = 2;
	localparam int CFG_PULSE    = 4;
	localparam int ADDR_TAKEN   = 7;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET   = 8'h00;
	localparam logic [7:0] HIGH_RESET   = 8'hff;
	localparam logic [7:0] LOW_RESET    = 8'h00;
	localparam logic [6:0] ADDR_RESET   = 7'h00;

	// ----------------------------------------
	// slave address and pin levels
	// ----------------------------------------
	localparam logic [4:0] ADDR_UPPER = 5'h0b;
	localparam logic [1:0] LVL_GND    = 2'h0;
	localparam logic [1:0] LVL_OPEN   = 2'h1;
	localparam logic [1:0] LVL_VCC    = 2'h2;

	typedef enum logic [1:0] {
		PIN_ADDR  = 2'h0,
		PIN_RESET = 2'h1,
		PIN_IRQ   = 2'h2
	} pin_fn_e;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_WAIT = 2'b10
	} seq_state_e;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int RST_PULSE_MS     = 20;
	localparam int RST_PULSE_CYCLES =
		(RST_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ### rtl/adc_sequencer.sv
`timescale 1ns/10ps
module adc_sequencer (
	input  wire logic                           hclk,
	input  wire logic                           hresetn,
	input  wire logic                           run,
	input  wire logic                           skip_first,
	input  wire logic                           adc_done,
	input  wire logic [hwmon_pkg::DATA_W-1:0]   adc_result,
	output logic                                adc_start,
	output logic      [hwmon_pkg::CH_W-1:0]     adc_channel,
	output logic                                result_valid,
	output logic      [hwmon_pkg::CH_W-1:0]     result_channel,
	output logic      [hwmon_pkg::DATA_W-1:0]   result_data
);

	hwmon_pkg::seq_state_e state;

	function automatic logic [hwmon_pkg::CH_W-1:0] step(
		input logic [hwmon_pkg::CH_W-1:0] ch,
		input logic                       skip
	);
		if (ch == hwmon_pkg::CH_LAST)
			return skip ? 3'h1 : hwmon_pkg::CH_12V;
		return ch + 3'h1;
	endfunction

	wire done_now = (state == hwmon_pkg::SEQ_WAIT) & adc_done;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state          <= hwmon_pkg::SEQ_IDLE;
			adc_start      <= 1'b0;
			adc_channel    <= hwmon_pkg::CH_12V;
			result_valid   <= 1'b0;
			result_channel <= hwmon_pkg::CH_12V;
			result_data    <= 8'h00;
		end else begin
			adc_start    <= 1'b0;
			result_valid <= 1'b0;
			unique case (state)
			hwmon_pkg::SEQ_IDLE: begin
				if (run) begin
					adc_channel <= skip_first ? 3'h1 : hwmon_pkg::CH_12V;
					adc_start   <= 1'b1;
					state       <= hwmon_pkg::SEQ_WAIT;
				end
			end
			hwmon_pkg::SEQ_WAIT: begin
				if (adc_done) begin
					result_valid   <= 1'b1;
					result_channel <= adc_channel;
					result_data    <= adc_result;
					adc_channel    <= step(adc_channel, skip_first);
					adc_start      <= run;
					state <= run ? hwmon_pkg::SEQ_WAIT : hwmon_pkg::SEQ_IDLE;
				end
			end
			default: state <= hwmon_pkg::SEQ_IDLE;
			endcase
		end
	end

	chan_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
		done_now && run |=> adc_start && adc_channel ==
		step($past(adc_channel), $past(skip_first)))
		else $error("channel did not step");

endmodule

// ### rtl/hw_monitor.sv
`timescale 1ns/10ps
module hw_monitor #(
	parameter int unsigned PULSE_CYCLES = hwmon_pkg::RST_PULSE_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	output logic             irq,
	input  wire logic        core_id_bit0,
	input  wire logic        core_id_bit1,
	input  wire logic        core_id_bit2,
	input  wire logic        core_id_bit3,
	input  wire logic        core_id_bit4,
	input  wire logic        tree_test_entry,
	input  wire logic [1:0]  mpin_level,
	output logic             mpin_out,
	output logic             mpin_oe,
	output logic             adc_start,
	output logic      [2:0]  adc_channel,
	input  wire logic        adc_done,
	input  wire logic [7:0]  adc_result
);

	localparam int PW = $clog2(PULSE_CYCLES + 1);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]    config_reg;
	logic [7:0]    mask;
	logic [7:0]    status;
	logic [7:0]    id_lo;
	logic [7:0]    id_hi;
	logic [6:0]    slave_addr;
	logic          addr_taken;
	logic          strap_taken;
	logic          test_mode;
	logic [7:0]    value  [hwmon_pkg::NUM_CH];
	logic [7:0]    high   [hwmon_pkg::NUM_CH];
	logic [7:0]    low    [hwmon_pkg::NUM_CH];
	logic [PW-1:0] pulse_cnt;
	logic          wr_pend;
	logic [31:0]   wr_addr;
	logic          res_valid;
	logic [2:0]    res_ch;
	logic [7:0]    res_data;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
		return a == {24'h0, off};
	endfunction

	function automatic logic in_bank(input logic [31:0] a,
		input logic [7:0] base);
		return a[31:5] == {24'h0, base[7:5]} && a[1:0] == 2'h0;
	endfunction

	wire       acc       = hsel & htrans[1] & hready;
	wire       rd_acc    = acc & ~hwrite;
	wire [2:0] rd_idx    = haddr[4:2];
	wire [2:0] wr_idx    = wr_addr[4:2];
	wire [7:0] wd        = hwdata[7:0];
	wire       wr_config = wr_pend & hit(wr_addr, hwmon_pkg::OFF_CONFIG);
	wire       wr_mask   = wr_pend & hit(wr_addr, hwmon_pkg::OFF_MASK);
	wire       wr_high   = wr_pend & in_bank(wr_addr, hwmon_pkg::OFF_HIGH);
	wire       wr_low    = wr_pend & in_bank(wr_addr, hwmon_pkg::OFF_LOW);
	wire       rd_status = rd_acc & hit(haddr, hwmon_pkg::OFF_STATUS);

	wire [7:0] rd_byte =
		hit(haddr, hwmon_pkg::OFF_CONFIG) ? config_reg :
		hit(haddr, hwmon_pkg::OFF_ID_LO)  ? id_lo :
		hit(haddr, hwmon_pkg::OFF_ID_HI)  ? id_hi :
		hit(haddr, hwmon_pkg::OFF_STATUS) ? status :
		hit(haddr, hwmon_pkg::OFF_MASK)   ? mask :
		hit(haddr, hwmon_pkg::OFF_ADDR)   ? {addr_taken, slave_addr} :
		hit(haddr, hwmon_pkg::OFF_TEST)   ? {7'h00, test_mode} :
		in_bank(haddr, hwmon_pkg::OFF_VALUE) ? value[rd_idx] :
		in_bank(haddr, hwmon_pkg::OFF_HIGH)  ? high[rd_idx] :
		in_bank(haddr, hwmon_pkg::OFF_LOW)   ? low[rd_idx] : 8'h00;

	// ----------------------------------------
	// derived control
	// ----------------------------------------
	wire digital4 = config_reg[hwmon_pkg::CFG_DIGITAL4];
	wire run      = config_reg[hwmon_pkg::CFG_RUN] & ~test_mode;
	// outside test mode, pin stays an address input until the address is taken
	wire [1:0] pin_fn = addr_taken ?
		config_reg[hwmon_pkg::CFG_FN_LO +: 2] : hwmon_pkg::PIN_ADDR;
	wire pulse_active = pulse_cnt != '0;
	wire pulse_go = wr_config & wd[hwmon_pkg::CFG_PULSE] & ~pulse_active &
		(pin_fn == hwmon_pkg::PIN_RESET);
	wire tree_nand = ~&{core_id_bit0, core_id_bit1, core_id_bit2,
		core_id_bit3, core_id_bit4};
	wire       out_hi = res_data > high[res_ch];
	wire       out_lo = res_data < low[res_ch];
	wire [7:0] flag_set = (res_valid & (out_hi | out_lo)) ?
		8'(1) << res_ch : 8'h00;
	wire [7:0] next_status = (rd_status ? 8'h00 : status) | flag_set;
	wire [1:0] addr_low =
		(mpin_level == hwmon_pkg::LVL_OPEN) ? 2'b10 :
		(mpin_level == hwmon_pkg::LVL_VCC)  ? 2'b01 : 2'b00;
	wire next_irq = |(status & mask);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 32'h0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= acc & hwrite;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (acc)
				wr_addr <= haddr;
			if (rd_acc)
				hrdata <= {24'h0, rd_byte};
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_reg <= hwmon_pkg::CONFIG_RESET;
			mask       <= hwmon_pkg::MASK_RESET;
		end else begin
			if (wr_config)
				config_reg <= {wd[7:5], 1'b0, wd[3:0]};
			if (wr_mask)
				mask <= wd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < hwmon_pkg::NUM_CH; i++) begin
				high[i] <= hwmon_pkg::HIGH_RESET;
				low[i]  <= hwmon_pkg::LOW_RESET;
			end
		end else begin
			if (wr_high)
				high[wr_idx] <= wd;
			if (wr_low)
				low[wr_idx] <= wd;
		end
	end

	// ----------------------------------------
	// measurement results and flags
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < hwmon_pkg::NUM_CH; i++)
				value[i] <= 8'h00;
			status <= 8'h00;
			irq    <= 1'b0;
		end else begin
			if (res_valid)
				value[res_ch] <= res_data;
			status <= next_status;
			irq    <= next_irq;
		end
	end

	// ----------------------------------------
	// core id capture
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			id_lo <= 8'h00;
			id_hi <= 8'h00;
		end else begin
			id_lo <= {4'h0, core_id_bit3, core_id_bit2,
				core_id_bit1, core_id_bit0};
			id_hi <= {7'h00, digital4 & core_id_bit4};
		end
	end

	// ----------------------------------------
	// strap, address, pulse
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_taken <= 1'b0;
			test_mode   <= 1'b0;
			addr_taken  <= 1'b0;
			slave_addr  <= hwmon_pkg::ADDR_RESET;
			pulse_cnt   <= '0;
		end else begin
			if (!strap_taken) begin
				strap_taken <= 1'b1;
				test_mode   <= tree_test_entry;
			end
			if (acc && !addr_taken) begin
				addr_taken <= 1'b1;
				slave_addr <= {hwmon_pkg::ADDR_UPPER, addr_low};
			end
			if (pulse_go)
				pulse_cnt <= PW'(PULSE_CYCLES);
			else if (pulse_active)
				pulse_cnt <= pulse_cnt - PW'(1);
		end
	end

	// ----------------------------------------
	// multipurpose pin
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mpin_out <= 1'b1;
			mpin_oe  <= 1'b0;
		end else if (test_mode) begin
			mpin_out <= tree_nand;
			mpin_oe  <= 1'b1;
		end else if (pin_fn == hwmon_pkg::PIN_RESET) begin
			mpin_out <= ~pulse_active;
			mpin_oe  <= pulse_active;
		end else if (pin_fn == hwmon_pkg::PIN_IRQ) begin
			mpin_out <= ~next_irq;
			mpin_oe  <= next_irq;
		end else begin
			mpin_out <= 1'b1;
			mpin_oe  <= 1'b0;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	adc_sequencer u_seq (
		.hclk           (hclk),
		.hresetn        (hresetn),
		.run            (run),
		.skip_first     (digital4),
		.adc_done       (adc_done),
		.adc_result     (adc_result),
		.adc_start      (adc_start),
		.adc_channel    (adc_channel),
		.result_valid   (res_valid),
		.result_channel (res_ch),
		.result_data    (res_data)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [PW:0] low_len;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			low_len <= '0;
		else if (pulse_active)
			low_len <= low_len + (PW+1)'(1);
		else
			low_len <= '0;
	end

	sequence pulse_req;
		pulse_go;
	endsequence
	sequence pin_low2;
		(pulse_active && mpin_oe && !mpin_out) [*2];
	endsequence

	id_lo_latch_a: assert property ($past(hresetn) |-> id_lo == {4'h0,
		$past(core_id_bit3), $past(core_id_bit2),
		$past(core_id_bit1), $past(core_id_bit0)})
		else $error("low id bits not latched");
	id4_analog_a: assert property (!digital4 |=> id_hi == 8'h00)
		else $error("id bit four not zero in analog mode");
	id4_digital_a: assert property (digital4 |=>
		id_hi[0] == $past(core_id_bit4))
		else $error("id bit four not captured");
	tree_out_a: assert property (test_mode |=>
		mpin_oe && mpin_out == $past(tree_nand))
		else $error("pin does not carry tree result");
	addr_hold_a: assert property (addr_taken |=> $stable(slave_addr))
		else $error("address changed after sampling");
	addr_form_a: assert property (acc && !addr_taken |=>
		addr_taken && slave_addr == {hwmon_pkg::ADDR_UPPER,
		$past(addr_low)})
		else $error("address not formed from pin");
	pulse_start_a: assert property (pulse_req |=> ##1 pin_low2)
		else $error("reset pulse did not start");
	pulse_len_a: assert property ($fell(pulse_active) |->
		low_len == (PW+1)'(PULSE_CYCLES))
		else $error("reset pulse length wrong");
	value_store_a: assert property (res_valid |=>
		value[$past(res_ch)] == $past(res_data))
		else $error("result not stored");
	limit_flag_a: assert property (res_valid && (out_hi || out_lo) |=>
		status[$past(res_ch)])
		else $error("limit flag not set");

endmodule

// ### testbench/adc_model.sv
`timescale 1ns/10ps
module adc_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       adc_start,
	input  wire logic [2:0] adc_channel,
	input  wire logic       slow,
	input  wire logic [7:0] base,
	output logic            adc_done,
	output logic      [7:0] adc_result
);
	// ----------------------------------------
	// converter: result is base plus channel
	// ----------------------------------------
	logic       busy;
	logic [2:0] ch;
	logic [2:0] wait_cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy       <= 1'b0;
			ch         <= 3'h0;
			wait_cnt   <= 3'h0;
			adc_done   <= 1'b0;
			adc_result <= 8'h00;
		end else begin
			adc_done   <= 1'b0;
			// result is only held for the done cycle
			adc_result <= ~adc_result;
			if (adc_start) begin
				busy     <= 1'b1;
				ch       <= adc_channel;
				wait_cnt <= slow ? 3'h4 : 3'h0;
			end else if (busy && wait_cnt == 3'h0) begin
				busy       <= 1'b0;
				adc_done   <= 1'b1;
				adc_result <= base + 8'(ch);
			end else if (busy) begin
				wait_cnt <= wait_cnt - 3'h1;
			end
		end
	end
endmodule

// ### testbench/test_hw_monitor.sv
`timescale 1ns/10ps
module test_hw_monitor;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0]  adc_result, base, v;
	logic [4:0]  id;
	logic [2:0]  adc_channel, nxt;
	logic [1:0]  htrans, mpin_level, lvl;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic        tree_test_entry, mpin_out, mpin_oe;
	logic        adc_start, adc_done, slow, skip, done_seen;
	int          bad_count, compares, n, k, i, seed;

	hw_monitor #(.PULSE_CYCLES(20)) i_hw_monitor (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .irq(irq), .core_id_bit0(id[0]),
		.core_id_bit1(id[1]), .core_id_bit2(id[2]), .core_id_bit3(id[3]),
		.core_id_bit4(id[4]), .tree_test_entry(tree_test_entry),
		.mpin_level(mpin_level), .mpin_out(mpin_out), .mpin_oe(mpin_oe),
		.adc_start(adc_start), .adc_channel(adc_channel),
		.adc_done(adc_done), .adc_result(adc_result));

	adc_model i_adc_model (.hclk(hclk), .hresetn(hresetn),
		.adc_start(adc_start), .adc_channel(adc_channel), .slow(slow),
		.base(base), .adc_done(adc_done), .adc_result(adc_result));

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic ready_wait;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			stop_test();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
			input logic [7:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		ready_wait();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		ready_wait();
		rd = hrdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd, {24'h0, e});
	endtask

	task automatic count_done(input int want);
		n = 0;
		k = 0;
		while (k < want && n < 600) begin
			@(negedge hclk);
			n++;
			if (adc_done === 1'b1) k++;
		end
		chk(32'(k), 32'(want));
		if (k < want) stop_test();
	endtask

	function automatic logic [7:0] addr_exp(input logic [1:0] l);
		return {1'b1, 5'h0b, l == 2'h0 ? 2'b00 : l == 2'h1 ? 2'b10 : 2'b01};
	endfunction

	// ----------------------------------------
	// clock and sequencer order watch
	// ----------------------------------------
	always #5 hclk = ~hclk;

	always @(posedge hclk) begin
		slow <= 1'($urandom);
	end

	always @(negedge hclk) begin
		if (hresetn !== 1'b1) begin
			nxt = 3'h0;
		end else if (adc_start === 1'b1) begin
			// fresh start at 0, or at 1 when channel 0 is skipped
			if (done_seen !== 1'b1)
				nxt = {2'h0, skip};
			else if (skip === 1'b1 && nxt == 3'h0)
				nxt = 3'h1;
			chk(32'(adc_channel), 32'(nxt));
			nxt = nxt + 3'h1;
		end
		done_seen = adc_done;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0;
		hwrite = 0; hwdata = 0; id = 0; tree_test_entry = 0; skip = 0;
		base = 0; bad_count = 0; compares = 0;
		seed = $urandom(44989);
		mpin_level = 2'($urandom % 3);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		lvl = mpin_level;
		// first access latches the address, so it reads something else
		rchk(hwmon_pkg::OFF_TEST, 8'h00);
		rchk(hwmon_pkg::OFF_ADDR, addr_exp(lvl));
		@(posedge hclk);
		mpin_level <= 2'((lvl + 1) % 3);
		rchk(hwmon_pkg::OFF_ADDR, addr_exp(lvl));
		rchk(8'hfc, 8'h00);
		chk(32'(hresp), 32'h0);
		$display("done: address");
		for (i = 0; i < 8; i++) begin
			v = 8'($urandom);
			@(posedge hclk);
			id <= v[4:0];
			if (i == 4) bus(1'b1, hwmon_pkg::OFF_CONFIG, 8'h02);
			rchk(hwmon_pkg::OFF_ID_LO, {4'h0, v[3:0]});
			rchk(hwmon_pkg::OFF_ID_HI, {7'h0, i >= 4 & v[4]});
		end
		@(posedge hclk);
		id <= 5'h1f;
		bus(1'b1, hwmon_pkg::OFF_CONFIG, 8'h00);
		rchk(hwmon_pkg::OFF_ID_HI, 8'h00);
		$display("done: core id");
		base = 8'h10 + 8'($urandom % 192);
		for (i = 0; i < 8; i++) begin
			bus(1'b1, hwmon_pkg::OFF_HIGH + 8'(4 * i),
				i == 3 ? base + 8'h02 : 8'hff);
			bus(1'b1, hwmon_pkg::OFF_LOW + 8'(4 * i),
				i == 5 ? base + 8'h06 : 8'h00);
		end
		bus(1'b1, hwmon_pkg::OFF_MASK, 8'h08);
		bus(1'b1, hwmon_pkg::OFF_CONFIG, 8'h09);
		count_done(12);
		bus(1'b1, hwmon_pkg::OFF_CONFIG, 8'h08);
		repeat (20) @(posedge hclk);
		for (i = 0; i < 8; i++) begin
			rchk(hwmon_pkg::OFF_VALUE + 8'(4 * i), base + 8'(i));
		end
		chk(32'(irq), 32'h1);
		chk(32'({mpin_oe, mpin_out}), 32'h2);
		rchk(hwmon_pkg::OFF_STATUS, 8'h28);
		rchk(hwmon_pkg::OFF_STATUS, 8'h00);
		chk(32'(irq), 32'h0);
		chk(32'(mpin_oe), 32'h0);
		$display("done: sequence");
		skip = 1'b1;
		bus(1'b1, hwmon_pkg::OFF_CONFIG, 8'h03);
		count_done(10);
		bus(1'b1, hwmon_pkg::OFF_CONFIG, 8'h02);
		repeat (20) @(posedge hclk);
		$display("done: digital sequence");
		bus(1'b1, hwmon_pkg::OFF_CONFIG, 8'h04);
		bus(1'b1, hwmon_pkg::OFF_CONFIG, 8'h14);
		k = 0;
		repeat (60) begin
			@(negedge hclk);
			if (mpin_oe === 1'b1 && mpin_out === 1'b0) k++;
		end
		chk(32'(k), 32'd20);
		rchk(hwmon_pkg::OFF_CONFIG, 8'h04);
		$display("done: reset pulse");
		@(posedge hclk);
		tree_test_entry <= 1'b1;
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(hwmon_pkg::OFF_TEST, 8'h01);
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'h1f : 8'($urandom);
			lvl = 2'($urandom % 3);
			@(posedge hclk);
			id <= v[4:0];
			mpin_level <= lvl;
			repeat (3) @(negedge hclk);
			chk(32'({mpin_oe, mpin_out}), {30'h0, 1'b1, ~&v[4:0]});
		end
		$display("done: tree test");
		stop_test();
	end
endmodule
